// ### logic/slp_prbs_checker.sv
// Purpose: Register file and top level of the eight-lane PRBS bit error checker
// Assumes: Lane bits come from deserialiser logic on clock_in; clock_in is twice the parallel clock
// Notes: Byte-wide plain register port, read data valid one cycle after the read strobe
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "slp_defines.svh"
module slp_prbs_checker #(
    parameter int LANES = 8
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [LANES-1:0] lane_bit_in,
    input wire logic [LANES-1:0] lane_valid_in,
    input wire logic [1:0] sync_error_in,
    output logic [1:0] sync_request_n_out,
    output logic [LANES-1:0] lane_pass_out
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] sync_len;
        logic [7:0] lane_en;
        logic [6:0] ctrl;
        logic [23:0] thr;
        logic [7:0] rdata;
    } slp_top_regs_t;

    slp_top_regs_t reg_q;
    slp_top_regs_t reg_d;

    logic [23:0] lane_count [LANES];
    logic [LANES-1:0] lane_pass;
    logic [23:0] sel_count;
    logic [7:0] rd_value;
    logic [2:0] count_sel;
    logic [3:0] sync_code;
    logic test_clear;
    logic test_run;
    slp_pkg::slp_pattern_t pattern;

    // ----------------------------------------
    // Control field decode
    // ----------------------------------------
    assign count_sel = reg_q.ctrl[`SLP_CTRL_SEL_MSB:`SLP_CTRL_SEL_LSB];
    assign pattern = slp_pkg::slp_pattern_t'(reg_q.ctrl[`SLP_CTRL_PAT_MSB:`SLP_CTRL_PAT_LSB]);
    assign test_run = reg_q.ctrl[`SLP_CTRL_RUN_BIT];
    assign test_clear = reg_q.ctrl[`SLP_CTRL_RESET_BIT];
    assign sync_code = reg_q.sync_len[`SLP_SYNC_CODE_MSB:`SLP_SYNC_CODE_LSB];

    // ----------------------------------------
    // Selected lane count
    // ----------------------------------------
    always_comb begin
        sel_count = 24'h0;
        for (int i = 0; i < LANES; i++) begin
            if (count_sel == 3'(i)) begin
                sel_count = lane_count[i];
            end
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        case (reg_addr_in)
            `SLP_ADDR_SYNC_LEN: begin
                rd_value = reg_q.sync_len;
            end
            `SLP_ADDR_LANE_EN: begin
                rd_value = reg_q.lane_en;
            end
            `SLP_ADDR_CTRL: begin
                // Top bit is reserved and reads zero
                rd_value = {1'b0, reg_q.ctrl};
            end
            `SLP_ADDR_THR_LO: begin
                rd_value = reg_q.thr[7:0];
            end
            `SLP_ADDR_THR_MID: begin
                rd_value = reg_q.thr[15:8];
            end
            `SLP_ADDR_THR_HI: begin
                rd_value = reg_q.thr[23:16];
            end
            `SLP_ADDR_CNT_LO: begin
                rd_value = sel_count[7:0];
            end
            `SLP_ADDR_CNT_MID: begin
                rd_value = sel_count[15:8];
            end
            `SLP_ADDR_CNT_HI: begin
                rd_value = sel_count[23:16];
            end
            `SLP_ADDR_PASS: begin
                rd_value = 8'(lane_pass);
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // ----------------------------------------
    // Register writes and read capture
    // ----------------------------------------
    always_comb begin
        reg_d = reg_q;
        // Read data stands only in the cycle after the strobe
        if (reg_rd_in) begin
            reg_d.rdata = rd_value;
        end else begin
            reg_d.rdata = 8'h00;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                `SLP_ADDR_SYNC_LEN: begin
                    reg_d.sync_len = reg_wdata_in;
                end
                `SLP_ADDR_LANE_EN: begin
                    reg_d.lane_en = reg_wdata_in;
                end
                `SLP_ADDR_CTRL: begin
                    reg_d.ctrl = reg_wdata_in[6:0];
                end
                `SLP_ADDR_THR_LO: begin
                    reg_d.thr[7:0] = reg_wdata_in;
                end
                `SLP_ADDR_THR_MID: begin
                    reg_d.thr[15:8] = reg_wdata_in;
                end
                `SLP_ADDR_THR_HI: begin
                    reg_d.thr[23:16] = reg_wdata_in;
                end
                default: begin
                    // Read-only and unmapped addresses ignore writes
                    reg_d.rdata = reg_d.rdata;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_q.sync_len <= `SLP_RST_SYNC_LEN;
            reg_q.lane_en <= `SLP_RST_LANE_EN;
            reg_q.ctrl <= `SLP_RST_CTRL;
            reg_q.thr <= `SLP_RST_THR;
            reg_q.rdata <= 8'h00;
        end else if (ce_in) begin
            reg_q <= reg_d;
        end
    end

    // ----------------------------------------
    // Lane checkers
    // ----------------------------------------
    // Enable holds a disabled lane's count and pass flag, but the control reset bit still clears that lane
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        slp_lane_checker u_lane (
            .clock_in(clock_in),
            .srst_in(srst_in),
            .ce_in(ce_in),
            .enable_in(reg_q.lane_en[g]),
            .clear_in(test_clear),
            .run_in(test_run),
            .pattern_in(pattern),
            .bit_in(lane_bit_in[g]),
            .valid_in(lane_valid_in[g]),
            .threshold_in(reg_q.thr),
            .count_out(lane_count[g]),
            .pass_out(lane_pass[g])
        );
    end

    // ----------------------------------------
    // Sync error pulses
    // ----------------------------------------
    // One shared code feeds both outputs
    for (genvar s = 0; s < 2; s++) begin : g_sync
        slp_sync_pulse u_sync (
            .clock_in(clock_in),
            .srst_in(srst_in),
            .ce_in(ce_in),
            .error_in(sync_error_in[s]),
            .code_in(sync_code),
            .sync_request_n_out(sync_request_n_out[s])
        );
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_out = reg_q.rdata;
    assign lane_pass_out = lane_pass;

endmodule
`default_nettype wire

// ### logic/slp_defines.svh
// Purpose: Offsets, field positions and reset values of the lane BER checker
// Assumes: 10-bit byte register addresses, 8-bit register data
// Notes: Definitions only
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SLP_ADDR_SYNC_LEN 10'h312
`define SLP_ADDR_LANE_EN 10'h315
`define SLP_ADDR_CTRL 10'h316
`define SLP_ADDR_THR_LO 10'h317
`define SLP_ADDR_THR_MID 10'h318
`define SLP_ADDR_THR_HI 10'h319
`define SLP_ADDR_CNT_LO 10'h31A
`define SLP_ADDR_CNT_MID 10'h31B
`define SLP_ADDR_CNT_HI 10'h31C
`define SLP_ADDR_PASS 10'h31D

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLP_SYNC_CODE_MSB 7
`define SLP_SYNC_CODE_LSB 4
`define SLP_CTRL_SEL_MSB 6
`define SLP_CTRL_SEL_LSB 4
`define SLP_CTRL_PAT_MSB 3
`define SLP_CTRL_PAT_LSB 2
`define SLP_CTRL_RUN_BIT 1
`define SLP_CTRL_RESET_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLP_RST_SYNC_LEN 8'h00
`define SLP_RST_LANE_EN 8'h00
`define SLP_RST_CTRL 7'h00
`define SLP_RST_THR 24'h000000
`define SLP_RST_PASS 8'hFF

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SLP_FILL_PRBS7 5'h07
`define SLP_FILL_PRBS15 5'h0F
`define SLP_FILL_PRBS31 5'h1F
`define SLP_CNT_MAX 24'hFFFFFF

`endif

// ### logic/slp_pkg.sv
// Purpose: Types shared by the lane BER checker files
// Assumes: Nothing beyond the defines header
// Notes: Holds enums and state structs only
package slp_pkg;
    typedef enum logic [1:0] {
        SLP_PAT_PRBS7 = 2'h0,
        SLP_PAT_PRBS15 = 2'h1,
        SLP_PAT_PRBS31 = 2'h2,
        SLP_PAT_UNUSED = 2'h3
    } slp_pattern_t;

    typedef enum logic [1:0] {
        SLP_ST_FILL = 2'h1,
        SLP_ST_CHECK = 2'h2
    } slp_lane_state_t;

    typedef struct packed {
        logic [30:0] hist;
        logic [4:0] fill;
        slp_lane_state_t st;
        logic [23:0] count;
        logic pass;
    } slp_lane_regs_t;

    typedef struct packed {
        logic busy;
        logic [4:0] left;
        logic sync_n;
    } slp_pulse_regs_t;
endpackage

// ### logic/slp_sync_pulse.sv
// Purpose: Low pulse on one sync-request output for a sync error report
// Assumes: clock_in runs at twice the parallel clock rate
// Notes: Low time is 2*code+1 clock_in cycles, i.e. (0.5 + code) parallel clocks
`timescale 1ns/100ps
`default_nettype none
module slp_sync_pulse (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic error_in,
    input wire logic [3:0] code_in,
    output logic sync_request_n_out
);
    slp_pkg::slp_pulse_regs_t reg_q;
    slp_pkg::slp_pulse_regs_t reg_d;

    always_comb begin
        reg_d = reg_q;
        if (reg_q.busy) begin
            if (reg_q.left == 5'h00) begin
                reg_d.busy = 1'b0;
                reg_d.sync_n = 1'b1;
            end else begin
                reg_d.left = reg_q.left - 5'h01;
            end
        end else if (error_in) begin
            // Half-cycle granularity from the double-rate clock
            reg_d.busy = 1'b1;
            reg_d.sync_n = 1'b0;
            reg_d.left = {code_in, 1'b0};
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_q <= '{busy: 1'b0, left: 5'h00, sync_n: 1'b1};
        end else if (ce_in) begin
            reg_q <= reg_d;
        end
    end

    assign sync_request_n_out = reg_q.sync_n;
endmodule
`default_nettype wire

// ### logic/slp_lane_checker.sv
// Purpose: Self-synchronising PRBS checker and error counter for one lane
// Assumes: One received bit per clock_in cycle when valid_in is high
// Notes: Predicts each bit from the received history, so no seed is needed
`timescale 1ns/100ps
`default_nettype none
`include "slp_defines.svh"
module slp_lane_checker (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire logic clear_in,
    input wire logic run_in,
    input wire slp_pkg::slp_pattern_t pattern_in,
    input wire logic bit_in,
    input wire logic valid_in,
    input wire logic [23:0] threshold_in,
    output logic [23:0] count_out,
    output logic pass_out
);
    slp_pkg::slp_lane_regs_t reg_q;
    slp_pkg::slp_lane_regs_t reg_d;
    logic pred;
    logic [4:0] fill_len;

    always_comb begin
        case (pattern_in)
            slp_pkg::SLP_PAT_PRBS7: begin
                pred = reg_q.hist[6] ^ reg_q.hist[5];
                fill_len = `SLP_FILL_PRBS7;
            end
            slp_pkg::SLP_PAT_PRBS15: begin
                pred = reg_q.hist[14] ^ reg_q.hist[13];
                fill_len = `SLP_FILL_PRBS15;
            end
            slp_pkg::SLP_PAT_PRBS31: begin
                pred = reg_q.hist[30] ^ reg_q.hist[27];
                fill_len = `SLP_FILL_PRBS31;
            end
            default: begin
                pred = 1'b0;
                fill_len = `SLP_FILL_PRBS31;
            end
        endcase
    end

    always_comb begin
        reg_d = reg_q;
        if (clear_in) begin
            reg_d = '{hist: 31'h0, fill: 5'h00, st: slp_pkg::SLP_ST_FILL, count: 24'h0, pass: 1'b1};
        end else if (enable_in) begin
            if (run_in && valid_in && pattern_in != slp_pkg::SLP_PAT_UNUSED) begin
                reg_d.hist = {reg_q.hist[29:0], bit_in};
                case (reg_q.st)
                    slp_pkg::SLP_ST_FILL: begin
                        // History must hold a full register before predictions mean anything
                        reg_d.fill = reg_q.fill + 5'h01;
                        if (reg_d.fill == fill_len) begin
                            reg_d.st = slp_pkg::SLP_ST_CHECK;
                        end
                    end
                    slp_pkg::SLP_ST_CHECK: begin
                        if (bit_in != pred && reg_q.count != `SLP_CNT_MAX) begin
                            reg_d.count = reg_q.count + 24'h1;
                        end
                    end
                    default: begin
                        reg_d.st = slp_pkg::SLP_ST_FILL;
                    end
                endcase
            end
            if (reg_q.count > threshold_in) begin
                reg_d.pass = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_q <= '{hist: 31'h0, fill: 5'h00, st: slp_pkg::SLP_ST_FILL, count: 24'h0, pass: 1'b1};
        end else if (ce_in) begin
            reg_q <= reg_d;
        end
    end

    assign count_out = reg_q.count;
    assign pass_out = reg_q.pass;
endmodule
`default_nettype wire

// ### dv/slp_prbs_checker_assertions.sv
// Purpose: Port-level checks of the lane BER checker
// Assumes: No sync code write while a pulse runs
// Notes: Bound to slp_prbs_checker
`timescale 1ns/100ps
`default_nettype none
module slp_prbs_checker_assertions #(
    parameter int LANES = 8
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [LANES-1:0] lane_bit_in,
    input wire logic [LANES-1:0] lane_valid_in,
    input wire logic [1:0] sync_error_in,
    input wire logic [1:0] sync_request_n_out,
    input wire logic [LANES-1:0] lane_pass_out
);
    // ------------
    // Shadow state
    // ------------
    logic [3:0] code_q;
    logic [LANES-1:0] en_q;
    logic rst_q;
    logic [5:0] low0_q;
    logic [5:0] low1_q;
    logic wr_on;
    assign wr_on = reg_wr_in && ce_in;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            code_q <= 4'h0;
            en_q <= '0;
            rst_q <= 1'b0;
        end else begin
            if (wr_on && reg_addr_in == 10'h312)
                code_q <= reg_wdata_in[7:4];
            if (wr_on && reg_addr_in == 10'h315)
                en_q <= reg_wdata_in[LANES-1:0];
            if (wr_on && reg_addr_in == 10'h316)
                rst_q <= reg_wdata_in[0];
        end
        low0_q <= sync_request_n_out[0] ? 6'h00 : low0_q + 6'h01;
        low1_q <= sync_request_n_out[1] ? 6'h00 : low1_q + 6'h01;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_rd(a);
        reg_rd_in && ce_in && reg_addr_in == a;
    endsequence
    a_rdata_idle: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero");
    a_pass_read: assert property (s_rd(10'h31D) |=> reg_rdata_out == $past(lane_pass_out))
        else $error("pass register mismatch");
    a_sync_start: assert property (ce_in && sync_error_in[0] && sync_request_n_out[0] |=> !sync_request_n_out[0])
        else $error("sync pulse not started");
    a_sync_len0: assert property ($rose(sync_request_n_out[0]) |-> low0_q == {1'b0, code_q, 1'b1})
        else $error("sync pulse 0 wrong length");
    a_sync_len1: assert property ($rose(sync_request_n_out[1]) |-> low1_q == {1'b0, code_q, 1'b1})
        else $error("sync pulse 1 wrong length");
    a_pass_sticky: assert property (|(lane_pass_out & ~$past(lane_pass_out)) |-> $past(rst_q) || $past(rst_q, 2))
        else $error("pass flag rose without reset");
    a_fail_enabled: assert property ((~lane_pass_out & $past(lane_pass_out) & ~$past(en_q)) == '0)
        else $error("disabled lane failed");
    a_reset_pass: assert property (rst_q |-> ##2 lane_pass_out == '1)
        else $error("pass flags not set in reset");
endmodule
bind slp_prbs_checker slp_prbs_checker_assertions #(.LANES(LANES)) u_sva (
    .clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .lane_bit_in(lane_bit_in), .lane_valid_in(lane_valid_in),
    .sync_error_in(sync_error_in), .sync_request_n_out(sync_request_n_out), .lane_pass_out(lane_pass_out)
);
`default_nettype wire

// ### dv/slp_prbs_source.sv
// Purpose: Lane transmitter model sending PRBS bits
// Assumes: One bit per clock while sending
// Notes: A flip inverts the sent bit, not the sequence
`timescale 1ns/100ps
`default_nettype none
module slp_prbs_source (
    input wire logic clock_in,
    input wire logic send_in,
    input wire logic [1:0] pattern_in,
    input wire logic [7:0] flip_in,
    output logic [7:0] lane_bit_out,
    output logic [7:0] lane_valid_out
);
    logic [30:0] hist_q = 31'h7FFFFFFF;
    logic nxt;
    initial lane_bit_out = 8'h00;
    initial lane_valid_out = 8'h00;
    always_comb begin
        case (pattern_in)
            2'h0: nxt = hist_q[6] ^ hist_q[5];
            2'h1: nxt = hist_q[14] ^ hist_q[13];
            default: nxt = hist_q[30] ^ hist_q[27];
        endcase
    end
    always @(posedge clock_in) begin
        if (send_in) begin
            hist_q <= {hist_q[29:0], nxt};
            lane_bit_out <= {8{nxt}} ^ flip_in;
            lane_valid_out <= 8'hFF;
        end else begin
            // Toggle when idle so a stale bit never passes as data
            lane_bit_out <= ~lane_bit_out;
            lane_valid_out <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Purpose: Register-driven test of the lane BER checker
// Assumes: ce_in high except during one freeze test
// Notes: Error echoes give three counts per flipped bit
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic ce = 1'b1;
    logic [1:0] sync_err = 2'h0;
    logic send = 1'b0;
    logic [1:0] pat = 2'h0;
    logic [7:0] flip = 8'h00;
    logic [7:0] rdata, bits, valid, pass;
    logic [1:0] sync_n;
    logic [9:0] ra [8] = '{10'h312, 10'h315, 10'h316, 10'h317, 10'h318, 10'h319, 10'h31A, 10'h31D};
    logic [7:0] wd [8] = '{8'hA5, 8'h3C, 8'hFF, 8'h11, 8'h22, 8'h33, 8'h55, 8'h00};
    logic [7:0] rx [8] = '{8'hA5, 8'h3C, 8'h7F, 8'h11, 8'h22, 8'h33, 8'h00, 8'hFF};
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    int lo0, lo1;
    always #12.5 clock_in = ~clock_in;
    slp_prbs_checker #(.LANES(8)) u_dut (
        .clock_in(clock_in), .srst_in(srst_in), .ce_in(ce), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_stb), .reg_rd_in(rd_stb), .reg_rdata_out(rdata),
        .lane_bit_in(bits), .lane_valid_in(valid), .sync_error_in(sync_err),
        .sync_request_n_out(sync_n), .lane_pass_out(pass)
    );
    slp_prbs_source u_src (
        .clock_in(clock_in), .send_in(send), .pattern_in(pat), .flip_in(flip),
        .lane_bit_out(bits), .lane_valid_out(valid)
    );
    task automatic tally_and_finish;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        compares++;
        if (got !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock_in);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clock_in);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock_in);
        rd_stb <= 1'b0;
        @(negedge clock_in);
        chk(rdata, e);
    endtask
    task automatic start(input logic [1:0] p, input logic [7:0] en);
        wr(10'h316, {4'h0, p, 2'h1});
        pat <= p;
        wr(10'h316, {4'h0, p, 2'h0});
        wr(10'h315, en);
        wr(10'h316, {4'h0, p, 2'h2});
    endtask
    // Flips 41 bits apart so error echoes never overlap
    task automatic burst(input logic [7:0] m1, input logic [7:0] m2);
        @(posedge clock_in);
        send <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            repeat (40) @(posedge clock_in);
            flip <= (k == 0) ? m1 : (k == 1) ? m2 : 8'h00;
            @(posedge clock_in);
            flip <= 8'h00;
        end
        send <= 1'b0;
        repeat (3) @(posedge clock_in);
    endtask
    task automatic cnt(input logic [2:0] l, input logic [1:0] p, input logic [7:0] e);
        wr(10'h316, {1'b0, l, p, 2'h0});
        rd(10'h31A, e);
    endtask
    initial begin
        repeat (8) @(posedge clock_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd(10'h312 + 10'(i), (i == 11) ? 8'hFF : 8'h00);
        end
        rd(10'h300, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ra[i], wd[i]);
            rd(ra[i], rx[i]);
        end
        wr(10'h316, 8'h00);
        // Clock enable low must swallow the write
        ce <= 1'b0;
        wr(10'h315, 8'h77);
        @(posedge clock_in);
        ce <= 1'b1;
        rd(10'h315, 8'h3C);
        $display("register test done");
        wr(10'h317, 8'h03);
        wr(10'h318, 8'h00);
        wr(10'h319, 8'h00);
        for (int p = 0; p < 3; p++) begin
            start(2'(p), 8'hFF);
            burst(8'h05, 8'h04);
            wr(10'h316, {4'h0, 2'(p), 2'h0});
            for (int l = 0; l < 8; l++) begin
                cnt(3'(l), 2'(p), (l == 0) ? 8'h03 : (l == 2) ? 8'h06 : 8'h00);
            end
            cnt(3'h2, 2'(p), 8'h06);
            rd(10'h31B, 8'h00);
            rd(10'h31C, 8'h00);
            rd(10'h31D, 8'hFB);
            chk(pass, 8'hFB);
        end
        $display("pattern test done");
        wr(10'h316, 8'h21);
        rd(10'h31A, 8'h00);
        rd(10'h31D, 8'hFF);
        start(2'h0, 8'hFF);
        wr(10'h316, 8'h00);
        burst(8'h01, 8'h00);
        cnt(3'h0, 2'h0, 8'h00);
        start(2'h0, 8'hFE);
        burst(8'h01, 8'h04);
        wr(10'h316, 8'h00);
        cnt(3'h0, 2'h0, 8'h00);
        cnt(3'h2, 2'h0, 8'h03);
        start(2'h3, 8'hFF);
        burst(8'h04, 8'h00);
        cnt(3'h2, 2'h3, 8'h00);
        $display("control test done");
        for (int c = 0; c < 16; c += 5) begin
            wr(10'h312, {4'(c), 4'h0});
            sync_err <= 2'h3;
            @(posedge clock_in);
            sync_err <= 2'h0;
            lo0 = 0;
            lo1 = 0;
            repeat (40) begin
                @(negedge clock_in);
                lo0 += (sync_n[0] === 1'b0) ? 1 : 0;
                lo1 += (sync_n[1] === 1'b0) ? 1 : 0;
            end
            chk(8'(lo0), 8'(2 * c + 1));
            chk(8'(lo1), 8'(2 * c + 1));
        end
        $display("sync test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
